// [logic/lrc_cell.sv]
// logic cell in normal mode: lut, register, three outputs, chain
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
// Behaviour
// - the register works as a d, t, jk or sr flip-flop, chosen by control.
// - the register has data, load data, clock, enable, clear, load inputs.
// - an asserted load copies the fourth data input, or a one when preset is set, into the register.
// - a combinational function sends the lut result past the register.
// - each of the three outputs picks lut result or register on its own.
// - two outputs feed row, column and neighbour routes, one feeds local.
// - the register output can be fed back as a lut input of the same cell.
// - registered and unregistered lut copies can be out at the same time.
// - four data inputs address the lut, the fourth swappable for carry in.
// - the lut result goes straight to the next cell on a chain output.
// - the register may be loaded from a source unrelated to the lut.
// - carry in is taken as lut input only at the end of an adder chain.
module lrc_cell (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [lrc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [lrc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [lrc_pkg::DATA_W-1:0] reg_rdata,
   input wire logic cell_in0,
   input wire logic cell_in1,
   input wire logic cell_in2,
   input wire logic fourth_data_input,
   input wire logic carry_in,
   input wire logic cell_clk,
   input wire logic cell_ena,
   input wire logic cell_sclr,
   input wire logic cell_clr,
   input wire logic cell_aload,
   input wire logic packed_data,
   input wire logic reg_k,
   output logic local_out,
   output logic route_out_a,
   output logic neighbour_direct_route,
   output logic chain_out
);
   logic [lrc_pkg::LUT_W-1:0] lut_mask;
   logic [lrc_pkg::CTRL_W-1:0] ctrl;
   logic [lrc_pkg::LUT_W-1:0] next_lut_mask;
   logic [lrc_pkg::CTRL_W-1:0] next_ctrl;
   logic [lrc_pkg::DATA_W-1:0] next_reg_rdata;
   logic cell_clk_d;
   logic next_cell_clk_d;
   logic next_local_out;
   logic next_route_out_a;
   logic next_neighbour_direct_route;
   logic next_chain_out;
   logic cell_q;
   logic lut_res;
   logic lut_in0;
   logic lut_in3;
   logic use_carry;
   logic reg_d;
   logic tick;
   logic aload_val;
   logic [3:0] lut_idx;
   lrc_pkg::lrc_ff_mode_t ff_mode;

   // register port
   always_comb begin
      next_lut_mask = lut_mask;
      next_ctrl = ctrl;
      next_reg_rdata = '0;
      if (reg_wr) begin
         if (reg_addr == lrc_pkg::OFF_LUT) begin
            next_lut_mask = reg_wdata[lrc_pkg::LUT_W-1:0];
         end else if (reg_addr == lrc_pkg::OFF_CTRL) begin
            next_ctrl = reg_wdata[lrc_pkg::CTRL_W-1:0];
         end
      end
      // unmapped addresses read as zero
      if (reg_rd) begin
         if (reg_addr == lrc_pkg::OFF_LUT) begin
            next_reg_rdata[lrc_pkg::LUT_W-1:0] = lut_mask;
         end else if (reg_addr == lrc_pkg::OFF_CTRL) begin
            next_reg_rdata[lrc_pkg::CTRL_W-1:0] = ctrl;
         end else if (reg_addr == lrc_pkg::OFF_STATUS) begin
            next_reg_rdata[lrc_pkg::STAT_Q] = cell_q;
            next_reg_rdata[lrc_pkg::STAT_LUT] = lut_res;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         lut_mask <= lrc_pkg::LUT_RST;
         ctrl <= lrc_pkg::CTRL_RST;
         reg_rdata <= '0;
      end else begin
         lut_mask <= next_lut_mask;
         ctrl <= next_ctrl;
         reg_rdata <= next_reg_rdata;
      end
   end

   // look-up table and register feeds
   always_comb begin
      ff_mode = lrc_pkg::lrc_ff_mode_t'(ctrl[lrc_pkg::CTRL_MODE_LSB +: 2]);
      // carry is ignored unless the cell closes an adder chain
      use_carry = ctrl[lrc_pkg::CTRL_CARRY]
                & ctrl[lrc_pkg::CTRL_CHAIN_END];
      lut_in3 = use_carry ? carry_in : fourth_data_input;
      lut_in0 = ctrl[lrc_pkg::CTRL_FB] ? cell_q : cell_in0;
      lut_idx = {lut_in3, cell_in2, cell_in1, lut_in0};
      lut_res = lut_mask[lut_idx];
      // packed mode frees the register from the lut
      reg_d = ctrl[lrc_pkg::CTRL_PACKED] ? packed_data : lut_res;
      aload_val = ctrl[lrc_pkg::CTRL_PRESET]
                ? 1'b1 : fourth_data_input;
      // cell clock is a plain synchronous input; its rising edge ticks while cell_ena is high
      tick = cell_clk & ~cell_clk_d & cell_ena;
   end

   lrc_ff_core u_ff (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .mode(ff_mode),
      .d(reg_d),
      .k(reg_k),
      .tick(tick),
      .sclr(cell_sclr),
      .clr(cell_clr),
      .aload(cell_aload),
      .aload_val(aload_val),
      .q(cell_q)
   );

   // output selection; every output is retimed by one flop
   always_comb begin
      next_cell_clk_d = cell_clk;
      next_local_out = ctrl[lrc_pkg::CTRL_OSEL_LOCAL]
                     ? cell_q : lut_res;
      next_route_out_a = ctrl[lrc_pkg::CTRL_OSEL_A]
                       ? cell_q : lut_res;
      next_neighbour_direct_route = ctrl[lrc_pkg::CTRL_OSEL_B]
                                  ? cell_q : lut_res;
      next_chain_out = lut_res;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cell_clk_d <= 1'b0;
         local_out <= 1'b0;
         route_out_a <= 1'b0;
         neighbour_direct_route <= 1'b0;
         chain_out <= 1'b0;
      end else begin
         cell_clk_d <= next_cell_clk_d;
         local_out <= next_local_out;
         route_out_a <= next_route_out_a;
         neighbour_direct_route <= next_neighbour_direct_route;
         chain_out <= next_chain_out;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_LOAD_DATA: assert property (
      (cell_aload && !cell_clr && !ctrl[lrc_pkg::CTRL_PRESET])
      |=> cell_q == $past(fourth_data_input))
      else $error("load did not take fourth data input");
   AST_PRESET: assert property (
      (cell_aload && !cell_clr && ctrl[lrc_pkg::CTRL_PRESET]) |=> cell_q)
      else $error("preset did not set the register");
   AST_CLEAR: assert property (
      (cell_clr && tick) |=> !cell_q)
      else $error("clear lost against the cell clock");
   AST_LUT_BYPASS: assert property (
      !ctrl[lrc_pkg::CTRL_OSEL_LOCAL] |=> local_out == $past(lut_res))
      else $error("local output not the lut result");
   AST_REG_OUT: assert property (
      ctrl[lrc_pkg::CTRL_OSEL_A] |=> route_out_a == $past(cell_q))
      else $error("route output not the register");
   AST_NEIGHBOUR: assert property (
      !ctrl[lrc_pkg::CTRL_OSEL_B]
      |=> neighbour_direct_route == $past(lut_res))
      else $error("neighbour route not the lut result");
   AST_CHAIN: assert property (
      ##1 chain_out == $past(lut_res))
      else $error("chain output lags wrong");
   AST_NO_CARRY: assert property (
      (!ctrl[lrc_pkg::CTRL_CHAIN_END] && !ctrl[lrc_pkg::CTRL_FB])
      |-> lut_res == lut_mask[{fourth_data_input, cell_in2, cell_in1,
                                cell_in0}])
      else $error("carry used away from chain end");
   AST_FEEDBACK: assert property (
      (ctrl[lrc_pkg::CTRL_FB] && !use_carry)
      |-> lut_res == lut_mask[{fourth_data_input, cell_in2, cell_in1,
                                cell_q}])
      else $error("register not fed back into lut");
   AST_PACKED: assert property (
      (ctrl[lrc_pkg::CTRL_PACKED] && ff_mode == lrc_pkg::LRC_FF_D && tick
       && !cell_clr && !cell_aload && !cell_sclr)
      |=> cell_q == $past(packed_data))
      else $error("packed register missed its data");
   AST_CTRL_READ: assert property (
      (reg_rd && reg_addr == lrc_pkg::OFF_CTRL)
      |=> reg_rdata[lrc_pkg::CTRL_W-1:0] == $past(ctrl))
      else $error("control readback wrong");

   // register port: writes act next cycle, read data stand one cycle only
   AST_LUT_WRITE: assert property (
      (reg_wr && reg_addr == lrc_pkg::OFF_LUT)
      |=> lut_mask == $past(reg_wdata[lrc_pkg::LUT_W-1:0]))
      else $error("lut mask write lost");
   AST_CTRL_WRITE: assert property (
      (reg_wr && reg_addr == lrc_pkg::OFF_CTRL)
      |=> ctrl == $past(reg_wdata[lrc_pkg::CTRL_W-1:0]))
      else $error("control write lost");
   AST_STATUS_RO: assert property (
      (reg_wr && reg_addr == lrc_pkg::OFF_STATUS)
      |=> lut_mask == $past(lut_mask) && ctrl == $past(ctrl))
      else $error("status write changed a register");
   AST_LUT_READ: assert property (
      (reg_rd && reg_addr == lrc_pkg::OFF_LUT)
      |=> reg_rdata[lrc_pkg::LUT_W-1:0] == $past(lut_mask))
      else $error("lut mask readback wrong");
   AST_STATUS_READ: assert property (
      (reg_rd && reg_addr == lrc_pkg::OFF_STATUS)
      |=> reg_rdata[lrc_pkg::STAT_Q] == $past(cell_q)
          && reg_rdata[lrc_pkg::STAT_LUT] == $past(lut_res))
      else $error("status readback wrong");
   AST_RDATA_IDLE: assert property (
      !reg_rd |=> reg_rdata == '0)
      else $error("read data stood past its cycle");
   AST_UNMAPPED_READ: assert property (
      (reg_rd && reg_addr != lrc_pkg::OFF_LUT
       && reg_addr != lrc_pkg::OFF_CTRL && reg_addr != lrc_pkg::OFF_STATUS)
      |=> reg_rdata == '0)
      else $error("unmapped read not zero");

   // output selection, each output on its own
   AST_LOCAL_REG: assert property (
      ctrl[lrc_pkg::CTRL_OSEL_LOCAL] |=> local_out == $past(cell_q))
      else $error("local output not the register");
   AST_ROUTE_LUT: assert property (
      !ctrl[lrc_pkg::CTRL_OSEL_A]
      |=> route_out_a == $past(lut_res))
      else $error("route output not the lut result");
   AST_NEIGHBOUR_REG: assert property (
      ctrl[lrc_pkg::CTRL_OSEL_B]
      |=> neighbour_direct_route == $past(cell_q))
      else $error("neighbour route not the register");
   AST_BOTH_COPIES: assert property (
      (!ctrl[lrc_pkg::CTRL_OSEL_LOCAL] && ctrl[lrc_pkg::CTRL_OSEL_A])
      |=> local_out == $past(lut_res) && route_out_a == $past(cell_q))
      else $error("lut copies not both out");
   AST_CARRY_IN: assert property (
      use_carry
      |-> lut_res == lut_mask[{carry_in, cell_in2, cell_in1, lut_in0}])
      else $error("carry not taken at chain end");

   // register controls; a held cell clock level must not clock again
   AST_SCLR: assert property (
      (tick && cell_sclr && !cell_clr && !cell_aload) |=> !cell_q)
      else $error("synchronous clear missed");
   AST_NO_ENABLE: assert property (
      (!cell_ena && !cell_clr && !cell_aload) |=> $stable(cell_q))
      else $error("register moved without enable");
   AST_LEVEL_NO_TICK: assert property (
      (cell_clk_d && !cell_clr && !cell_aload) |=> $stable(cell_q))
      else $error("register moved on a held clock level");
   AST_CLR_NO_ENABLE: assert property (
      (cell_clr && !cell_ena) |=> !cell_q)
      else $error("clear waited for enable");
   AST_LOAD_NO_CLOCK: assert property (
      (cell_aload && !cell_clr && !cell_clk)
      |=> cell_q == $past(aload_val))
      else $error("load waited for the cell clock");
   AST_PRESET_NO_ENABLE: assert property (
      (cell_aload && !cell_clr && ctrl[lrc_pkg::CTRL_PRESET] && !cell_ena)
      |=> cell_q)
      else $error("preset waited for enable");
   AST_SR_HOLD: assert property (
      (ff_mode == lrc_pkg::LRC_FF_SR && tick && reg_d && reg_k
       && !cell_clr && !cell_aload && !cell_sclr)
      |=> $stable(cell_q))
      else $error("sr with both inputs did not hold");
   AST_JK_TOGGLE: assert property (
      (ff_mode == lrc_pkg::LRC_FF_JK && tick && reg_d && reg_k
       && !cell_clr && !cell_aload && !cell_sclr)
      |=> cell_q != $past(cell_q))
      else $error("jk with both inputs did not toggle");

   COV_BOTH_COPIES: cover property (
      !ctrl[lrc_pkg::CTRL_OSEL_LOCAL] && ctrl[lrc_pkg::CTRL_OSEL_A]
      && !ctrl[lrc_pkg::CTRL_PACKED] && tick);
   COV_CARRY_END: cover property (use_carry && carry_in);
   COV_CLR_LOAD: cover property (cell_clr && cell_aload);
   COV_FEEDBACK_TICK: cover property (ctrl[lrc_pkg::CTRL_FB] && tick);
endmodule // lrc_cell

// [logic/lrc_pkg.sv]
// constants and types shared by the logic cell files
package lrc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int LUT_W = 16;
   localparam int CTRL_W = 10;
   localparam int STAT_W = 2;
   // register offsets (byte addresses, one word each)
   localparam logic [7:0] OFF_LUT = 8'h00;
   localparam logic [7:0] OFF_CTRL = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   // reset values
   localparam logic [15:0] LUT_RST = 16'h0000;
   localparam logic [9:0] CTRL_RST = 10'h000;
   // control field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_CARRY = 2;
   localparam int CTRL_CHAIN_END = 3;
   localparam int CTRL_FB = 4;
   localparam int CTRL_PACKED = 5;
   localparam int CTRL_PRESET = 6;
   localparam int CTRL_OSEL_LOCAL = 7;
   localparam int CTRL_OSEL_A = 8;
   localparam int CTRL_OSEL_B = 9;
   // status field positions
   localparam int STAT_Q = 0;
   localparam int STAT_LUT = 1;
   typedef enum logic [1:0] {
      LRC_FF_D,
      LRC_FF_T,
      LRC_FF_JK,
      LRC_FF_SR
   } lrc_ff_mode_t;
endpackage

// [logic/lrc_ff_core.sv]
// configurable storage element of the logic cell
`timescale 1ns/10ps
module lrc_ff_core (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire lrc_pkg::lrc_ff_mode_t mode,
   input wire logic d,
   input wire logic k,
   input wire logic tick,
   input wire logic sclr,
   input wire logic clr,
   input wire logic aload,
   input wire logic aload_val,
   output logic q
);
   logic next_q;

   always_comb begin
      next_q = q;
      if (clr) begin
         next_q = 1'b0;
      end else if (aload) begin
         next_q = aload_val;
      end else if (tick) begin
         if (sclr) begin
            next_q = 1'b0;
         end else begin
            case (mode)
               lrc_pkg::LRC_FF_D: next_q = d;
               lrc_pkg::LRC_FF_T: next_q = q ^ d;
               lrc_pkg::LRC_FF_JK: next_q = (d & ~q) | (~k & q);
               // both set and reset high is illegal; hold keeps it harmless
               default: next_q = (d & ~k) ? 1'b1 : (k & ~d) ? 1'b0 : q;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         q <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_D_MODE: assert property (
      (mode == lrc_pkg::LRC_FF_D && tick && !clr && !aload && !sclr)
      |=> q == $past(d))
      else $error("d mode did not capture data");
   AST_T_MODE: assert property (
      (mode == lrc_pkg::LRC_FF_T && tick && d && !clr && !aload && !sclr)
      |=> q != $past(q))
      else $error("t mode did not toggle");
   AST_HOLD: assert property (
      (!tick && !clr && !aload) |=> $stable(q))
      else $error("register moved without enabled clock");
   AST_CLR_WINS: assert property (
      (clr && aload && aload_val) |=> !q)
      else $error("clear did not override load");
endmodule // lrc_ff_core

// [tb/lrc_route_model.sv]
// neighbour cell model: drives the carry into the cell
`timescale 1ns/10ps
module lrc_route_model (
   input wire logic ref_clk,
   input wire logic carry_req,
   output logic carry_in
);
   // carry comes from the previous cell's flop, so it lags one cycle
   always @(posedge ref_clk) begin
      carry_in <= carry_req;
   end
endmodule // lrc_route_model

// [tb/lrc_cell_tb_top.sv]
// self-checking bench for the logic cell in normal mode
`timescale 1ns/10ps
module lrc_cell_tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [3:0] idx = 4'h0;
   logic carry_req = 1'b0;
   logic carry_in;
   logic cell_clk = 1'b0;
   logic cell_ena = 1'b0;
   logic cell_sclr = 1'b0;
   logic cell_clr = 1'b0;
   logic cell_aload = 1'b0;
   logic packed_data = 1'b0;
   logic reg_k = 1'b0;
   logic lo, ra, nb, ch;
   int miscompares = 0;
   int checked = 0;
   lrc_route_model i_nbr (.ref_clk(ref_clk), .carry_req(carry_req),
      .carry_in(carry_in));
   lrc_cell i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cell_in0(idx[0]), .cell_in1(idx[1]),
      .cell_in2(idx[2]), .fourth_data_input(idx[3]), .carry_in(carry_in),
      .cell_clk(cell_clk), .cell_ena(cell_ena), .cell_sclr(cell_sclr),
      .cell_clr(cell_clr), .cell_aload(cell_aload),
      .packed_data(packed_data), .reg_k(reg_k), .local_out(lo),
      .route_out_a(ra), .neighbour_direct_route(nb), .chain_out(ch));
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic t(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic c1(input logic g, input logic e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %0t: output %b, want %b", $time, g, e);
      end
   endtask
   task automatic c32(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %0t: read %h, want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      t(1);
      reg_wr <= 1'b0;
      t(1);
   endtask
   // read data stand only in the cycle after the read edge
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      t(1);
      reg_rd <= 1'b0;
      #1 c32(reg_rdata, e);
      t(1);
   endtask
   task automatic outs(input logic [3:0] e);
      #1 c1(lo, e[3]);
      c1(ra, e[2]);
      c1(nb, e[1]);
      c1(ch, e[0]);
      t(1);
   endtask
   // one cell clock edge with enable, optional synchronous clear
   task automatic ev(input logic s);
      cell_clk <= 1'b1;
      cell_ena <= 1'b1;
      cell_sclr <= s;
      t(1);
      cell_clk <= 1'b0;
      cell_ena <= 1'b0;
      cell_sclr <= 1'b0;
      t(1);
   endtask
   task automatic as(input logic c, input logic l);
      cell_clr <= c;
      cell_aload <= l;
      t(1);
      cell_clr <= 1'b0;
      cell_aload <= 1'b0;
      t(1);
   endtask
   task automatic s_regs;
      rd(lrc_pkg::OFF_LUT, 32'h0);
      rd(lrc_pkg::OFF_CTRL, 32'h0);
      rd(8'h0C, 32'h0);
      wr(lrc_pkg::OFF_STATUS, 32'h3);
      rd(lrc_pkg::OFF_STATUS, 32'h0);
      wr(lrc_pkg::OFF_CTRL, 32'hFFFFFFFF);
      rd(lrc_pkg::OFF_CTRL, 32'h3FF);
      wr(lrc_pkg::OFF_CTRL, 32'h0);
   endtask
   task automatic s_lut;
      logic [15:0] m;
      m = 16'hA5C3;
      wr(lrc_pkg::OFF_LUT, {16'h0, m});
      for (int i = 0; i < 16; i++) begin
         idx <= i[3:0];
         t(1);
         outs({4{m[i]}});
      end
      idx <= 4'h0;
      wr(lrc_pkg::OFF_LUT, 32'hFF00);
      carry_req <= 1'b1;
      wr(lrc_pkg::OFF_CTRL, 32'h04);
      rd(lrc_pkg::OFF_STATUS, 32'h0);
      wr(lrc_pkg::OFF_CTRL, 32'h0C);
      rd(lrc_pkg::OFF_STATUS, 32'h2);
      carry_req <= 1'b0;
   endtask
   task automatic s_outs;
      wr(lrc_pkg::OFF_LUT, 32'hFFFF);
      wr(lrc_pkg::OFF_CTRL, 32'h80);
      ev(1'b0);
      wr(lrc_pkg::OFF_LUT, 32'h0);
      outs(4'b1000);
      wr(lrc_pkg::OFF_CTRL, 32'h300);
      outs(4'b0110);
      wr(lrc_pkg::OFF_LUT, 32'hFFFF);
      wr(lrc_pkg::OFF_CTRL, 32'h320);
      ev(1'b0);
      outs(4'b1001);
   endtask
   task automatic s_modes;
      wr(lrc_pkg::OFF_CTRL, 32'h1);
      ev(1'b0);
      rd(lrc_pkg::OFF_STATUS, 32'h3);
      ev(1'b0);
      rd(lrc_pkg::OFF_STATUS, 32'h2);
      wr(lrc_pkg::OFF_CTRL, 32'h2);
      ev(1'b0);
      rd(lrc_pkg::OFF_STATUS, 32'h3);
      reg_k <= 1'b1;
      ev(1'b0);
      rd(lrc_pkg::OFF_STATUS, 32'h2);
      wr(lrc_pkg::OFF_CTRL, 32'h3);
      ev(1'b0);
      rd(lrc_pkg::OFF_STATUS, 32'h2);
      reg_k <= 1'b0;
      ev(1'b0);
      rd(lrc_pkg::OFF_STATUS, 32'h3);
      reg_k <= 1'b1;
      ev(1'b0);
      rd(lrc_pkg::OFF_STATUS, 32'h3);
      wr(lrc_pkg::OFF_CTRL, 32'h0);
      ev(1'b1);
      rd(lrc_pkg::OFF_STATUS, 32'h2);
   endtask
   task automatic s_async;
      wr(lrc_pkg::OFF_LUT, 32'h0);
      idx <= 4'h8;
      as(1'b0, 1'b1);
      rd(lrc_pkg::OFF_STATUS, 32'h1);
      as(1'b1, 1'b1);
      rd(lrc_pkg::OFF_STATUS, 32'h0);
      wr(lrc_pkg::OFF_CTRL, 32'h40);
      idx <= 4'h0;
      as(1'b0, 1'b1);
      rd(lrc_pkg::OFF_STATUS, 32'h1);
      wr(lrc_pkg::OFF_LUT, 32'hAAAA);
      wr(lrc_pkg::OFF_CTRL, 32'h10);
      rd(lrc_pkg::OFF_STATUS, 32'h3);
      as(1'b1, 1'b0);
      rd(lrc_pkg::OFF_STATUS, 32'h0);
   endtask
   task automatic test_done;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      t(16);
      rst_n <= 1'b1;
      t(1);
      s_regs;
      s_lut;
      s_outs;
      s_modes;
      s_async;
      test_done;
   end
   // the whole run needs well under 1000 cycles
   initial begin
      t(3000);
      miscompares++;
      $display("unexpected %0t: run did not finish", $time);
      test_done;
   end
endmodule // lrc_cell_tb_top
